// ### rtc_host.sv
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module rtc_host
  import rtc_host_pkg::*;
#(
  parameter int POR_WAIT = POR_WAIT_CYC,
  parameter int READBACK_LIMIT = READBACK_CYC,
  parameter int QUARTER = QUARTER_CYC
)(
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  output logic SCL_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O
);

  typedef enum logic [1:0] {S_IDLE, S_START, S_BIT, S_STOP} state_t;

  state_t state_r;
  logic [1:0] phase_r, sda_sync_r;
  logic [3:0] bit_r;
  logic [2:0] idx_r, nbytes_r, buf_idx;
  logic [7:0] sh_r, st2_r, rdata_r;
  logic [7:0] buf_r [MAX_BYTES];
  logic [31:0] por_cnt_r, rb_cnt_r;
  cfg_t cfg_r, xfer_r;
  logic recov_r, err_r, scl_r, sda_oe_r, sda_s, tick, end_evt, end_ok;
  logic ready_r, init_pend_r, st2_known_r, done_r, nack_r, refused_r;
  logic late_r, armed_r, go_wr, rec_wr, refuse, launch_go, launch_rec;
  logic tx_byte, rx_byte;

  pace_divider #(.COUNT(QUARTER)) u_pace (
    .clk_i(CORE_CLK_I),
    .rst_i(RESET_I),
    .tick_o(tick)
  );

  // Two flip-flops bring the data line into the core clock domain.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      sda_sync_r <= 2'b11;
    else
      sda_sync_r <= {sda_sync_r[0], SDA_I};
  end
  assign sda_s = sda_sync_r[1];

  // Requests and their refusal checks.
  assign go_wr = WR_I && (ADDR_I == REG_CTRL) && WDATA_I[CTRL_GO];
  assign rec_wr = WR_I && (ADDR_I == REG_CTRL) && WDATA_I[CTRL_RECOVER];
  assign refuse = !ready_r || init_pend_r || (state_r != S_IDLE) // RULE19
    || (cfg_r.kind == K_INTREG && !st2_known_r) // RULE1
    || (cfg_r.kind == K_ALMEXP && !cfg_r.rw && !st2_known_r) // RULE12
    || (cfg_r.kind == K_UPCNT && !cfg_r.rw) // RULE9
    || (cfg_r.kind == K_FREE23 && (cfg_r.sel[0] == cfg_r.sel[1])) // RULE10
    || (cfg_r.kind == K_STATUS && cfg_r.sel[0] && !cfg_r.rw
        && is_conflict(buf_r[0])); // RULE4
  assign launch_rec = ready_r && (state_r == S_IDLE)
    && (init_pend_r || rec_wr); // RULE17
  assign launch_go = go_wr && !refuse && !launch_rec;
  assign tx_byte = !recov_r && ((idx_r == 3'd0) || !xfer_r.rw);
  assign rx_byte = !recov_r && (idx_r != 3'd0) && xfer_r.rw; // RULE25
  assign end_evt = tick && (state_r == S_STOP) && (phase_r == 2'd3);
  assign end_ok = end_evt && !recov_r && !err_r;
  assign buf_idx = 3'(ADDR_I - REG_BUF);

  // Power-on wait, then one recovery sequence before normal use.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      por_cnt_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      init_pend_r <= 1'b1;
    end
    else
    begin
      if (!ready_r && por_cnt_r == 32'(POR_WAIT - 1))
        ready_r <= 1'b1; // RULE19
      else if (!ready_r)
        por_cnt_r <= por_cnt_r + 32'h0000_0001;
      if (launch_rec)
        init_pend_r <= 1'b0; // RULE17
    end
  end

  // Bit engine: each bit is four quarter periods of the link clock.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      state_r <= S_IDLE;
      phase_r <= 2'd0;
      bit_r <= 4'h0;
      idx_r <= 3'd0;
      nbytes_r <= 3'd0;
      sh_r <= 8'hFF;
      recov_r <= 1'b0;
      err_r <= 1'b0;
      scl_r <= 1'b1;
      sda_oe_r <= 1'b0;
      xfer_r <= '0;
    end
    else if (launch_rec || launch_go)
    begin
      state_r <= S_START;
      phase_r <= 2'd0;
      bit_r <= 4'h0;
      idx_r <= 3'd0;
      err_r <= 1'b0;
      recov_r <= launch_rec;
      xfer_r <= cfg_r;
      nbytes_r <= byte_count(cfg_r, st2_r); // RULE2 RULE3
      sh_r <= launch_rec ? 8'hFF : first_byte(cfg_r); // RULE26
    end
    else if (tick && state_r != S_IDLE)
    begin
      phase_r <= phase_r + 2'd1;
      unique case (state_r)
        S_START:
        begin
          if (phase_r == 2'd1)
            sda_oe_r <= 1'b1; // RULE23 RULE15
          if (phase_r == 2'd3)
          begin
            scl_r <= 1'b0;
            state_r <= S_BIT;
          end
        end
        S_BIT:
        begin
          if (phase_r == 2'd0 && bit_r != LAST_BIT)
            sda_oe_r <= tx_byte && !sh_r[7]; // RULE25 RULE15
          if (phase_r == 2'd0 && bit_r == LAST_BIT)
            sda_oe_r <= rx_byte && (idx_r != nbytes_r); // RULE7 RULE8
          if (phase_r == 2'd1)
            scl_r <= 1'b1;
          if (phase_r == 2'd2 && bit_r != LAST_BIT)
            sh_r <= {sh_r[6:0], sda_s};
          if (phase_r == 2'd2 && bit_r == LAST_BIT && tx_byte && sda_s)
            err_r <= 1'b1;
          if (phase_r == 2'd3)
          begin
            scl_r <= 1'b0;
            if (bit_r != LAST_BIT)
              bit_r <= bit_r + 4'h1;
            else if (recov_r || err_r || idx_r == nbytes_r)
              state_r <= S_STOP; // RULE16
            else
            begin
              bit_r <= 4'h0;
              idx_r <= idx_r + 3'd1;
              sh_r <= xfer_r.rw ? 8'hFF : buf_r[idx_r];
            end
          end
        end
        S_STOP:
        begin
          if (phase_r == 2'd0)
            sda_oe_r <= 1'b1;
          if (phase_r == 2'd1)
            scl_r <= 1'b1;
          if (phase_r == 2'd2)
            sda_oe_r <= 1'b0; // RULE23 RULE16
          if (phase_r == 2'd3)
            state_r <= S_IDLE;
        end
        S_IDLE: scl_r <= 1'b1;
      endcase
    end
  end

  // Data buffer: software fills it while idle, reads land in it.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      for (int i = 0; i < MAX_BYTES; i++)
        buf_r[i] <= 8'h00;
    else if (tick && state_r == S_BIT && phase_r == 2'd3
             && bit_r == LAST_BIT && rx_byte)
      buf_r[idx_r - 3'd1] <= sh_r;
    else if (WR_I && state_r == S_IDLE && ADDR_I >= REG_BUF
             && buf_idx < 3'(MAX_BYTES) && ADDR_I < REG_BUF + 8'h08)
      buf_r[buf_idx] <= WDATA_I;
  end

  // Configuration and the second status register shadow.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      cfg_r <= '0;
      st2_r <= 8'h00;
      st2_known_r <= 1'b0;
    end
    else
    begin
      if (WR_I && ADDR_I == REG_CFG)
        cfg_r <= cfg_t'(WDATA_I);
      if (end_ok && xfer_r.kind == K_STATUS && xfer_r.sel[0])
      begin
        st2_r <= buf_r[0]; // RULE1
        st2_known_r <= 1'b1;
      end
    end
  end

  // Sticky status flags; a launch clears done and nack ahead of an end event, a refusal sets refused ahead of a clear.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      done_r <= 1'b0;
      nack_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      if (launch_go || launch_rec)
      begin
        done_r <= 1'b0;
        nack_r <= 1'b0;
      end
      else if (end_evt)
      begin
        done_r <= 1'b1;
        nack_r <= err_r;
      end
      if (go_wr && refuse)
        refused_r <= 1'b1;
      else if (launch_go)
        refused_r <= 1'b0;
    end
  end

  // Read-back window after writing the first real-time data.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      armed_r <= 1'b0;
      rb_cnt_r <= 32'h0000_0000;
      late_r <= 1'b0;
    end
    else
    begin
      if (end_ok && xfer_r.kind == K_RTD1)
      begin
        armed_r <= !xfer_r.rw; // RULE20
        rb_cnt_r <= 32'h0000_0000;
      end
      else if (armed_r && rb_cnt_r == 32'(READBACK_LIMIT - 1))
        armed_r <= 1'b0;
      else if (armed_r)
        rb_cnt_r <= rb_cnt_r + 32'h0000_0001;
      if (armed_r && rb_cnt_r == 32'(READBACK_LIMIT - 1))
        late_r <= 1'b1; // RULE20
      else if (WR_I && ADDR_I == REG_CTRL && WDATA_I[CTRL_CLR_LATE])
        late_r <= 1'b0;
    end
  end

  // Read port: data stands in the cycle after the strobe only.
  always_ff @(posedge CORE_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      rdata_r <= 8'h00;
    else if (!RD_I)
      rdata_r <= 8'h00;
    else if (ADDR_I == REG_CFG)
      rdata_r <= cfg_r;
    else if (ADDR_I == REG_STAT)
      rdata_r <= stat_t'({2'b00, ready_r, late_r, refused_r, nack_r,
                          done_r, state_r != S_IDLE});
    else if (ADDR_I == REG_ST2)
      rdata_r <= st2_r;
    else if (ADDR_I >= REG_BUF && ADDR_I < REG_BUF + 8'h07)
      rdata_r <= buf_r[buf_idx];
    else
      rdata_r <= 8'h00;
  end

  assign RDATA_O = rdata_r;
  assign SCL_O = scl_r;
  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe_r;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);

  a_por_quiet: assert property (!ready_r |-> scl_r && !sda_oe_r) // RULE19
    else $error("link active during power-on wait");
  a_start_edge: assert property ($rose(sda_oe_r) && scl_r // RULE23
    |-> $past(state_r) == S_START)
    else $error("data fell with clock high outside start");
  a_stop_edge: assert property ($fell(sda_oe_r) && scl_r // RULE16
    |-> $past(state_r) == S_STOP)
    else $error("data rose with clock high outside stop");
  a_read_ack: assert property (state_r == S_BIT && bit_r == LAST_BIT // RULE7
    && scl_r && rx_byte && idx_r != nbytes_r |-> sda_oe_r)
    else $error("read byte not acknowledged");
  a_read_nack: assert property (state_r == S_BIT && bit_r == LAST_BIT // RULE8
    && scl_r && rx_byte && idx_r == nbytes_r |-> !sda_oe_r)
    else $error("last read byte acknowledged");
  a_recover_free: assert property (recov_r && state_r == S_BIT // RULE15
    && scl_r |-> !sda_oe_r)
    else $error("data driven during recovery clocks");
  a_recover_stop: assert property (tick && recov_r && state_r == S_BIT // RULE16
    && bit_r == LAST_BIT && phase_r == 2'd3 |=> state_r == S_STOP)
    else $error("no stop after nine recovery clocks");
  a_msb_first: assert property (state_r == S_BIT && bit_r != LAST_BIT // RULE25
    && phase_r == 2'd2 && scl_r && tx_byte |-> sda_oe_r == !sh_r[7])
    else $error("transmitted bit is not the top bit");
  a_first_code: assert property (state_r == S_START && !recov_r // RULE26
    |-> sh_r[0] == xfer_r.rw && (sh_r[7:4] == DEV_CODE
    || sh_r[7:4] == DEV_CODE_EXT))
    else $error("first byte malformed");
  a_int_order: assert property (go_wr && cfg_r.kind == K_INTREG // RULE1
    && !st2_known_r && state_r == S_IDLE && !init_pend_r && !rec_wr
    |=> state_r == S_IDLE && refused_r)
    else $error("interrupt access before status set");
  a_exp_order: assert property (go_wr && cfg_r.kind == K_ALMEXP // RULE12
    && !cfg_r.rw && !st2_known_r && state_r == S_IDLE && !init_pend_r
    && !rec_wr |=> state_r == S_IDLE)
    else $error("expansion write before status set");

  c_write_done: cover property (end_ok && !xfer_r.rw);
  c_read_three: cover property (end_ok && xfer_r.rw && nbytes_r == 3'd3);
  c_recovery: cover property (end_evt && recov_r);
  c_nack: cover property (end_evt && err_r);

endmodule : rtc_host

// ### rtc_host_pkg.sv
package rtc_host_pkg;

  // What the document requires
  // [RULE1] Program second status register before interrupt registers.
  // [RULE2] Alarm mode makes interrupt registers three bytes.
  // [RULE3] Frequency mode makes them one frequency byte.
  // [RULE4] Never combine first alarm with frequency output.
  // [RULE5] Status selector bit: zero first, one second.
  // [RULE6] Interrupt selector bit: zero first, one second.
  // [RULE7] Master acknowledges every read byte but last.
  // [RULE8] Master leaves data high on last byte.
  // [RULE9] Elapsed-minute counter is read only.
  // [RULE10] Spare selector: zero-one second, one-zero third.
  // [RULE11] Alarm expansion selector: zero first, one second.
  // [RULE12] Write alarm expansion only after second status.
  // [RULE13] Broken transfer freezes device until a stop.
  // [RULE14] Device ignores start and stop while driving low.
  // [RULE15] Recovery: start, nine clocks, data line released.
  // [RULE16] Stop after recovery clocks resets device interface.
  // [RULE17] Run recovery at initialisation after power-up.
  // [RULE18] Recovery during write acknowledge may complete write.
  // [RULE19] No transfer during half second after power-on.
  // [RULE20] Read back real-time data within one second.
  // [RULE21] Device outputs one hertz after power-on.
  // [RULE22] One hertz continues until registers are initialised.
  // [RULE23] Start and stop are data edges with clock high.
  // [RULE24] Device acknowledges each received byte, not irregular ones.
  // [RULE25] Read bit one reads; bytes go most significant first.
  // [RULE26] First byte holds device code, command, direction.

  // Timing.
  localparam int CLK_HZ = 10_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);
  localparam int POR_WAIT_MS = 500;
  localparam int POR_WAIT_CYC = (CLK_HZ / 1000) * POR_WAIT_MS;
  localparam int READBACK_MS = 1000;
  localparam int READBACK_CYC = (CLK_HZ / 1000) * READBACK_MS;
  localparam logic [3:0] LAST_BIT = 4'h8;

  // Software register offsets and control bits.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h01;
  localparam logic [7:0] REG_STAT = 8'h02;
  localparam logic [7:0] REG_ST2 = 8'h03;
  localparam logic [7:0] REG_BUF = 8'h10;
  localparam int MAX_BYTES = 7;
  localparam int CTRL_GO = 0;
  localparam int CTRL_RECOVER = 1;
  localparam int CTRL_CLR_LATE = 2;

  // Device codes of the first byte; values are arbitrary.
  localparam logic [3:0] DEV_CODE = 4'hA;
  localparam logic [3:0] DEV_CODE_EXT = 4'hB;

  // Command bits for each register group.
  localparam logic [2:0] CMD_STATUS = 3'h0;
  localparam logic [2:0] CMD_RTD1 = 3'h2;
  localparam logic [2:0] CMD_RTD2 = 3'h3;
  localparam logic [2:0] CMD_INTREG = 3'h4;
  localparam logic [2:0] CMD_CORR = 3'h6;
  localparam logic [2:0] CMD_FREE1 = 3'h7;
  localparam logic [2:0] CMD_UPCNT = 3'h0;
  localparam logic [2:0] CMD_FREE23 = 3'h0;
  localparam logic [2:0] CMD_ALMEXP = 3'h4;

  // Mode fields of the second status register.
  localparam logic [7:0] ST2_FIRST_INTERRUPT_OUTPUT_MASK = 8'hE0;
  localparam logic [7:0] ST2_FIRST_INTERRUPT_OUTPUT_ALARM = 8'h20;
  localparam logic [7:0] ST2_FIRST_INTERRUPT_OUTPUT_FREQ = 8'hA0;
  localparam logic [7:0] ST2_SECOND_INTERRUPT_OUTPUT_MASK = 8'h0E;
  localparam logic [7:0] ST2_SECOND_INTERRUPT_OUTPUT_ALARM = 8'h02;
  localparam logic [7:0] ST2_SECOND_INTERRUPT_OUTPUT_FREQ = 8'h0A;

  typedef enum logic [3:0] {K_STATUS, K_RTD1, K_RTD2, K_INTREG, K_CORR,
    K_FREE1, K_UPCNT, K_FREE23, K_ALMEXP} kind_t;

  typedef struct packed {
    logic rw;
    logic [1:0] sel;
    logic spare;
    kind_t kind;
  } cfg_t;

  typedef struct packed {
    logic [1:0] zero;
    logic ready;
    logic late;
    logic refused;
    logic nack;
    logic done;
    logic busy;
  } stat_t;

  // Selector bits fold into the command field.
  function automatic logic [7:0] first_byte(input cfg_t c);
    logic [2:0] cmd;
    logic [3:0] dev;
    cmd = CMD_STATUS;
    dev = DEV_CODE;
    case (c.kind)
      K_STATUS: cmd = CMD_STATUS | {2'b00, c.sel[0]}; // RULE5
      K_RTD1: cmd = CMD_RTD1;
      K_RTD2: cmd = CMD_RTD2;
      K_INTREG: cmd = CMD_INTREG | {2'b00, c.sel[0]}; // RULE6
      K_CORR: cmd = CMD_CORR;
      K_FREE1: cmd = CMD_FREE1;
      K_UPCNT: cmd = CMD_UPCNT;
      K_FREE23: cmd = CMD_FREE23 | {1'b0, c.sel}; // RULE10
      K_ALMEXP: cmd = CMD_ALMEXP | {2'b00, c.sel[0]}; // RULE11
      default: cmd = CMD_STATUS;
    endcase
    if (c.kind == K_UPCNT || c.kind == K_FREE23 || c.kind == K_ALMEXP)
      dev = DEV_CODE_EXT;
    first_byte = {dev, cmd, c.rw}; // RULE26 RULE25
  endfunction : first_byte

  function automatic logic is_alarm(input logic [7:0] st2, input logic s);
    is_alarm = s ? ((st2 & ST2_SECOND_INTERRUPT_OUTPUT_MASK) == ST2_SECOND_INTERRUPT_OUTPUT_ALARM)
                 : ((st2 & ST2_FIRST_INTERRUPT_OUTPUT_MASK) == ST2_FIRST_INTERRUPT_OUTPUT_ALARM);
  endfunction : is_alarm

  function automatic logic is_conflict(input logic [7:0] st2);
    logic frq;
    frq = ((st2 & ST2_FIRST_INTERRUPT_OUTPUT_MASK) == ST2_FIRST_INTERRUPT_OUTPUT_FREQ) ||
          ((st2 & ST2_SECOND_INTERRUPT_OUTPUT_MASK) == ST2_SECOND_INTERRUPT_OUTPUT_FREQ);
    is_conflict = (is_alarm(st2, 1'b0) || is_alarm(st2, 1'b1)) && frq;
  endfunction : is_conflict

  // Data bytes after the first byte.
  function automatic logic [2:0] byte_count(input cfg_t c,
                                            input logic [7:0] st2);
    case (c.kind)
      K_RTD1: byte_count = 3'd7;
      K_RTD2: byte_count = 3'd3;
      K_UPCNT: byte_count = 3'd3;
      K_INTREG: byte_count = is_alarm(st2, c.sel[0]) ? 3'd3 : 3'd1;
      default: byte_count = 3'd1;
    endcase
  endfunction : byte_count

endpackage : rtc_host_pkg

// ### pace_divider.sv
`timescale 1ns/1ns
module pace_divider
#(
  parameter int COUNT = 25
)(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);

  logic [15:0] cnt_r;

  // Free-running count that pulses once every COUNT cycles.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b0;
    end
    else if (cnt_r == 16'(COUNT - 1))
    begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule : pace_divider

// ### rtc_dev_model.sv
`timescale 1ns/1ns
module rtc_dev_model
  import rtc_host_pkg::*;
#(
  parameter bit STUCK = 1'b1
)(
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_i,
  output logic low_o
);
  logic [7:0] mem [128][7];
  logic [7:0] sh, fb, tx, first_seen;
  logic act = 1'b0;
  logic rdm = 1'b0;
  logic mnack = 1'b0;
  int bitn = 0, nbyte = 0, served = 0, acked = 0, stops = 0;
  int clocks = 0, clocks_at_stop = 0;
  // Half period of the power-on wave, scaled down to keep runs short.
  localparam int PULSE_NS = 2000;
  logic first_interrupt_output = 1'b1;
  logic set_up = 1'b0;
  int pulses = 0;

  // The power-on wave runs until the second status register is written.
  always #PULSE_NS
    if (!set_up)
    begin
      first_interrupt_output = ~first_interrupt_output;
      pulses++;
    end

  // A device cut off mid-read powers up holding the data line low.
  initial
  begin
    low_o = STUCK;
  end

  // A falling data line with the clock high opens a transfer.
  always @(negedge sda_i)
    if (scl_i === 1'b1 && !low_o)
    begin
      act = 1'b1;
      bitn = -1;
      nbyte = 0;
      mnack = 1'b0;
    end

  // A rising data line with the clock high clears the interface.
  always @(posedge sda_i)
    if (scl_i === 1'b1)
    begin
      act = 1'b0;
      stops++;
      clocks_at_stop = clocks;
      clocks = 0;
    end

  // Bits are taken while the clock is high, most significant first.
  always @(posedge scl_i)
  begin
    if (act && bitn < 8 && (nbyte == 0 || !rdm))
      sh = {sh[6:0], sda_i};
    if (act && bitn == 8 && rdm && nbyte > 0)
      if (sda_i)
        mnack = 1'b1;
      else
        acked++;
  end

  // The data line only changes while the clock is low.
  always @(negedge scl_i)
  begin
    clocks++;
    if (STUCK && clocks <= 4 && stops == 0)
      low_o = (clocks < 4);
    else if (act)
    begin
      if (bitn < 7)
      begin
        bitn++;
        low_o = rdm && nbyte > 0 && !tx[7 - bitn];
      end
      else if (bitn == 7)
      begin
        bitn = 8;
        if (nbyte == 0)
          low_o = (sh[7:4] == DEV_CODE || sh[7:4] == DEV_CODE_EXT);
        else
          low_o = !rdm && !nack_i;
        if (!rdm && nbyte > 0 && low_o
            && fb[7:1] != {DEV_CODE_EXT, CMD_UPCNT})
        begin
          mem[fb[7:1]][nbyte - 1] = sh;
          set_up |= (fb[7:1] == {DEV_CODE, CMD_STATUS | 3'h1});
        end
      end
      else
      begin
        bitn = 0;
        if (nbyte == 0)
          fb = sh;
        first_seen = fb;
        rdm = fb[0];
        act = low_o || (rdm && nbyte > 0 && !mnack);
        nbyte++;
        tx = mem[fb[7:1]][(nbyte - 1) % 7];
        if (act && rdm)
          served++;
        low_o = act && rdm && !tx[7];
      end
    end
  end
endmodule : rtc_dev_model

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import rtc_host_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic nack = 1'b0;
  logic rd_late = 1'b0;
  logic [7:0] rdata, v;
  logic scl, sda_o, sda_oe, dev_low, sda_w;
  logic [15:0] notes[$];
  logic [15:0] nt;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 1;
  int k0, k1;

  // Core clock at 10 MHz.
  initial
  begin
    forever #50 clk = ~clk;
  end

  // The data line has a pull-up; either party may pull it low.
  assign sda_w = ~((sda_oe & ~sda_o) | dev_low);

  rtc_host #(.POR_WAIT(50), .READBACK_LIMIT(5000), .QUARTER(4)) uut (
    .CORE_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SCL_O(scl), .SDA_I(sda_w),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe));

  rtc_dev_model #(.STUCK(1'b1)) dev (.scl_i(scl), .sda_i(sda_w),
    .nack_i(nack), .low_o(dev_low));

  // Each read answer is compared with the oldest note of mask and value.
  always @(negedge clk)
  begin
    if (rd_late && notes.size() > 0)
    begin
      nt = notes.pop_front();
      check_count++;
      if ((rdata & nt[15:8]) !== nt[7:0])
      begin
        n_mismatch++;
        $display("[ERR] RDATA_O exp %h seen %h", nt[7:0], rdata & nt[15:8]);
      end
    end
    rd_late = rd;
  end

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %0h seen %0h", what, e, s);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] n,
                        output logic [7:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    notes.push_back(n);
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask : rd_reg

  task automatic poll(input logic [7:0] m, input logic [7:0] e);
    int i;
    for (i = 0; i < 2000; i++)
    begin
      rd_reg(REG_STAT, 16'h0000, v);
      if ((v & m) === e)
        break;
    end
    chk("status wait", 1, i < 2000);
  endtask : poll

  function automatic logic [7:0] cf(input logic rw, input logic [1:0] s,
                                    input kind_t k);
    cf = {rw, s, 1'b0, k};
  endfunction : cf

  task automatic go(input logic [7:0] c);
    wr_reg(REG_CFG, c);
    wr_reg(REG_CTRL, 8'h01);
    poll(8'h01, 8'h00);
  endtask : go

  // A refused request leaves the link silent and sets the refused flag.
  task automatic refuse(input logic [7:0] c, input logic [7:0] d);
    int st;
    st = dev.stops;
    wr_reg(REG_BUF, d);
    go(c);
    rd_reg(REG_STAT, 16'h0808, v);
    chk("stops", st, dev.stops);
  endtask : refuse

  task automatic do_write(input kind_t k, input logic [1:0] s,
                          input logic [6:0] key, input logic [7:0] d);
    wr_reg(REG_BUF, d);
    go(cf(1'b0, s, k));
    chk("first byte", {key, 1'b0}, dev.first_seen);
    chk("stored", d, dev.mem[key][0]);
  endtask : do_write

  task automatic do_read(input kind_t k, input logic [1:0] s,
                         input logic [6:0] key, input int n);
    int sv;
    int ak;
    sv = dev.served;
    ak = dev.acked;
    if (key != {DEV_CODE, CMD_STATUS | 3'h1})
      for (int i = 0; i < 7; i++)
        dev.mem[key][i] = 8'($random(seed));
    go(cf(1'b1, s, k));
    chk("first byte", {key, 1'b1}, dev.first_seen);
    chk("bytes served", n, dev.served - sv);
    chk("master acks", n - 1, dev.acked - ak);
    chk("final nack", 1, dev.mnack);
    for (int i = 0; i < n; i++)
      rd_reg(REG_BUF + 8'(i), {8'hFF, dev.mem[key][i]}, v);
    rd_reg(REG_STAT, 16'h2722, v);
  endtask : do_read

  task automatic print_verdict();
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Main sequence.
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    rd_reg(REG_STAT, 16'h2000, v);
    refuse(cf(1'b1, 2'b00, K_RTD1), 8'h00);
    chk("quiet clock", 0, dev.clocks);
    poll(8'h21, 8'h20);
    chk("recovery clocks", 10, dev.clocks_at_stop);
    chk("recovery stop", 1, dev.stops);
    refuse(cf(1'b1, 2'b00, K_INTREG), 8'h00);
    refuse(cf(1'b0, 2'b00, K_ALMEXP), 8'h00);
    refuse(cf(1'b0, 2'b01, K_STATUS), 8'hA2);
    refuse(cf(1'b0, 2'b00, K_UPCNT), 8'h00);
    refuse(cf(1'b1, 2'b00, K_FREE23), 8'h00);
    refuse(cf(1'b1, 2'b11, K_FREE23), 8'h00);
    chk("power-on wave", 1, dev.pulses > 0);
    do_write(K_STATUS, 2'b01, {DEV_CODE, CMD_STATUS | 3'h1}, 8'h20);
    rd_reg(REG_ST2, 16'hFF20, v);
    k1 = dev.pulses;
    k0 = $random(seed);
    do_write(K_ALMEXP, 2'b01, {DEV_CODE_EXT, CMD_ALMEXP | 3'h1},
             8'(k0));
    do_read(K_STATUS, 2'b00, {DEV_CODE, CMD_STATUS}, 1);
    do_read(K_STATUS, 2'b01, {DEV_CODE, CMD_STATUS | 3'h1}, 1);
    do_read(K_RTD2, 2'b00, {DEV_CODE, CMD_RTD2}, 3);
    do_read(K_INTREG, 2'b00, {DEV_CODE, CMD_INTREG}, 3);
    do_read(K_INTREG, 2'b01, {DEV_CODE, CMD_INTREG | 3'h1}, 1);
    do_read(K_CORR, 2'b00, {DEV_CODE, CMD_CORR}, 1);
    do_read(K_FREE1, 2'b00, {DEV_CODE, CMD_FREE1}, 1);
    do_read(K_UPCNT, 2'b00, {DEV_CODE_EXT, CMD_UPCNT}, 3);
    do_read(K_FREE23, 2'b01, {DEV_CODE_EXT, CMD_FREE23 | 3'h1}, 1);
    do_read(K_FREE23, 2'b10, {DEV_CODE_EXT, CMD_FREE23 | 3'h2}, 1);
    do_read(K_ALMEXP, 2'b00, {DEV_CODE_EXT, CMD_ALMEXP}, 1);
    do_read(K_ALMEXP, 2'b01, {DEV_CODE_EXT, CMD_ALMEXP | 3'h1}, 1);
    nack <= 1'b1;
    k0 = dev.stops;
    wr_reg(REG_BUF, 8'h5A);
    go(cf(1'b0, 2'b00, K_FREE1));
    rd_reg(REG_STAT, 16'h0404, v);
    chk("stop after nack", k0 + 1, dev.stops);
    nack <= 1'b0;
    do_write(K_RTD1, 2'b00, {DEV_CODE, CMD_RTD1}, 8'h12);
    do_read(K_RTD1, 2'b00, {DEV_CODE, CMD_RTD1}, 7);
    repeat (6000) @(posedge clk);
    rd_reg(REG_STAT, 16'h1000, v);
    do_write(K_RTD1, 2'b00, {DEV_CODE, CMD_RTD1}, 8'h34);
    repeat (6000) @(posedge clk);
    rd_reg(REG_STAT, 16'h1010, v);
    wr_reg(REG_CTRL, 8'h04);
    rd_reg(REG_STAT, 16'h1000, v);
    wr_reg(REG_CTRL, 8'h02);
    poll(8'h01, 8'h00);
    chk("recovery clocks", 10, dev.clocks_at_stop);
    do_read(K_FREE1, 2'b00, {DEV_CODE, CMD_FREE1}, 1);
    chk("wave held", k1, dev.pulses);
    print_verdict();
  end

  // Cuts a hung run short well inside the cycle budget.
  initial
  begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_top
